// [rtl/gp_ports_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
module gp_ports_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output var logic [31:0] hrdata,
  output var logic hreadyout,
  output var logic hresp,
  input wire logic [7:0] port2_pad_in,
  input wire logic [7:0] port3_pad_in,
  input wire logic [7:0] port6_pad_in,
  input wire logic opamp_pin_output_enable,
  input wire logic reference_out_enable,
  input wire logic opamp_to_pin1_route_enable,
  input wire gp_pkg::gp_duty_t lcd_duty,
  output var gp_pkg::gp_pad_t [7:0] port2_pad,
  output var gp_pkg::gp_pad_t [7:0] port3_pad,
  output var gp_pkg::gp_pad_t [7:0] port6_pad,
  output var logic [7:0][5:0] lcd_segment_data
);

  gp_pkg::gp_top_state_t s_reg;
  gp_pkg::gp_top_state_t s_next;

  logic [7:0] port2_input_level;
  logic [7:0] port3_input_level;
  logic [7:0] port6_pin_input_level;
  logic [7:0] port3_hold;
  logic [7:0] port6_pin_output_enable;
  logic [7:0] port6_pin_input_enable;
  logic [7:0] port6_pin_output_value;
  logic accept;
  logic [5:0] duty_mask;
  logic take_wr;
  logic take_rd;
  logic [7:0] port2_hold;
  logic [7:0][7:0] p6_view;

  // ----------------------------------------
  // address decode
  // ----------------------------------------
  function automatic gp_pkg::gp_reg_t decode_addr(input logic [31:0] a);
    gp_pkg::gp_reg_t r;
    r = gp_pkg::reg_none;
    if (a == `GP_ADDR_P2_W0) begin
      r = gp_pkg::reg_p2_w0;
    end else if (a == `GP_ADDR_P2_W1) begin
      r = gp_pkg::reg_p2_w1;
    end else if (a == `GP_ADDR_P2_W2) begin
      r = gp_pkg::reg_p2_w2;
    end else if (a == `GP_ADDR_P3_W0) begin
      r = gp_pkg::reg_p3_w0;
    end else if (a == `GP_ADDR_P3_W1) begin
      r = gp_pkg::reg_p3_w1;
    end else if (a == `GP_ADDR_P3_W2) begin
      r = gp_pkg::reg_p3_w2;
    end else if (a == `GP_ADDR_P6_W0) begin
      r = gp_pkg::reg_p6_w0;
    end else if (a == `GP_ADDR_P6_W1) begin
      r = gp_pkg::reg_p6_w1;
    end else if (a == `GP_ADDR_P6_W2) begin
      r = gp_pkg::reg_p6_w2;
    end else if (a == `GP_ADDR_P6_W3) begin
      r = gp_pkg::reg_p6_w3;
    end else if (a == `GP_ADDR_LCD_MODE) begin
      r = gp_pkg::reg_lcd_mode;
    end
    return r;
  endfunction : decode_addr

  // ----------------------------------------
  // port 6 byte view
  // ----------------------------------------
  function automatic logic [7:0] p6_byte(
    input logic [5:0] cfg,
    input logic lvl,
    input logic lcd
  );
    logic [7:0] b;
    b = `GP_ZERO_BYTE;
    if (lcd) begin
      b[5:0] = cfg;
    end else begin
      b[`GP_P6_OE_BIT] = cfg[`GP_P6_OE_BIT];
      b[`GP_P6_IE_BIT] = cfg[`GP_P6_IE_BIT];
      b[`GP_P6_DO_BIT] = cfg[`GP_P6_DO_BIT];
      b[`GP_P6_DI_BIT] = lvl;
    end
    return b;
  endfunction : p6_byte

  function automatic logic [5:0] p6_store(
    input logic [5:0] cfg,
    input logic [7:0] wb,
    input logic lcd
  );
    logic [5:0] c;
    c = cfg;
    if (lcd) begin
      c = wb[5:0];
    end else begin
      c[`GP_P6_OE_BIT] = wb[`GP_P6_OE_BIT];
      c[`GP_P6_IE_BIT] = wb[`GP_P6_IE_BIT];
      c[`GP_P6_DO_BIT] = wb[`GP_P6_DO_BIT];
    end
    return c;
  endfunction : p6_store

  // ----------------------------------------
  // lcd duty mask
  // ----------------------------------------
  always_comb begin
    case (lcd_duty)
      gp_pkg::duty_1_3: duty_mask = `GP_MASK_D3;
      gp_pkg::duty_1_4: duty_mask = `GP_MASK_D4;
      gp_pkg::duty_1_5: duty_mask = `GP_MASK_D5;
      default: duty_mask = `GP_MASK_D6;
    endcase
  end

  assign accept = hsel & hready & htrans[`GP_HTRANS_ACT_BIT];
  assign take_wr = accept & hwrite;
  assign take_rd = accept & ~hwrite;

  // ----------------------------------------
  // port 6 read view
  // ----------------------------------------
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      p6_view[k] = p6_byte(s_reg.p6_cfg[k], port6_pin_input_level[k], s_reg.lcd_mode);
    end
  end

  // ----------------------------------------
  // register state
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.wr_pend = 1'b0;
    s_next.rd_pend = 1'b0;
    s_next.resp = 1'b0;
    // write data phase, zero wait
    if (s_reg.wr_pend) begin
      case (s_reg.addr_q)
        gp_pkg::reg_p2_w0: begin
          s_next.p2_pu = hwdata[`GP_HI_LSB +: 8];
          s_next.p2_oe = hwdata[`GP_LO_LSB +: 8];
        end
        gp_pkg::reg_p2_w1: begin
          s_next.p2_ie = hwdata[`GP_HI_LSB +: 8];
          s_next.p2_do = hwdata[`GP_LO_LSB +: 8];
        end
        gp_pkg::reg_p3_w0: begin
          s_next.p3_pu = hwdata[`GP_HI_LSB +: 8];
          s_next.p3_oe = hwdata[`GP_LO_LSB +: 8];
        end
        gp_pkg::reg_p3_w1: begin
          s_next.p3_ie = hwdata[`GP_HI_LSB +: 8];
          s_next.p3_do = hwdata[`GP_LO_LSB +: 8];
        end
        gp_pkg::reg_p6_w0: begin
          s_next.p6_cfg[0] = p6_store(s_reg.p6_cfg[0], hwdata[`GP_LO_LSB +: 8], s_reg.lcd_mode);
          s_next.p6_cfg[1] = p6_store(s_reg.p6_cfg[1], hwdata[`GP_HI_LSB +: 8], s_reg.lcd_mode);
        end
        gp_pkg::reg_p6_w1: begin
          s_next.p6_cfg[2] = p6_store(s_reg.p6_cfg[2], hwdata[`GP_LO_LSB +: 8], s_reg.lcd_mode);
          s_next.p6_cfg[3] = p6_store(s_reg.p6_cfg[3], hwdata[`GP_HI_LSB +: 8], s_reg.lcd_mode);
        end
        gp_pkg::reg_p6_w2: begin
          s_next.p6_cfg[4] = p6_store(s_reg.p6_cfg[4], hwdata[`GP_LO_LSB +: 8], s_reg.lcd_mode);
          s_next.p6_cfg[5] = p6_store(s_reg.p6_cfg[5], hwdata[`GP_HI_LSB +: 8], s_reg.lcd_mode);
        end
        gp_pkg::reg_p6_w3: begin
          s_next.p6_cfg[6] = p6_store(s_reg.p6_cfg[6], hwdata[`GP_LO_LSB +: 8], s_reg.lcd_mode);
          s_next.p6_cfg[7] = p6_store(s_reg.p6_cfg[7], hwdata[`GP_HI_LSB +: 8], s_reg.lcd_mode);
        end
        gp_pkg::reg_lcd_mode: begin
          s_next.lcd_mode = hwdata[`GP_LCD_MODE_BIT];
        end
        default: begin
          // read-only and unmapped words ignore writes
          s_next.resp = 1'b0;
        end
      endcase
    end
    // read: one wait cycle, then data
    if (s_reg.rd_pend) begin
      s_next.rdata = `GP_ZERO_WORD;
      s_next.readyout = 1'b1;
      case (s_reg.addr_q)
        gp_pkg::reg_p2_w0: begin
          s_next.rdata[`GP_HI_LSB +: 8] = s_reg.p2_pu;
          s_next.rdata[`GP_LO_LSB +: 8] = s_reg.p2_oe;
        end
        gp_pkg::reg_p2_w1: begin
          s_next.rdata[`GP_HI_LSB +: 8] = s_reg.p2_ie;
          s_next.rdata[`GP_LO_LSB +: 8] = s_reg.p2_do;
        end
        gp_pkg::reg_p2_w2: begin
          s_next.rdata[`GP_LO_LSB +: 8] = port2_input_level;
        end
        gp_pkg::reg_p3_w0: begin
          s_next.rdata[`GP_HI_LSB +: 8] = s_reg.p3_pu;
          s_next.rdata[`GP_LO_LSB +: 8] = s_reg.p3_oe;
        end
        gp_pkg::reg_p3_w1: begin
          s_next.rdata[`GP_HI_LSB +: 8] = s_reg.p3_ie;
          s_next.rdata[`GP_LO_LSB +: 8] = s_reg.p3_do;
        end
        gp_pkg::reg_p3_w2: begin
          s_next.rdata[`GP_ROUTE_BIT] = opamp_to_pin1_route_enable;
          s_next.rdata[`GP_LO_LSB +: 8] = port3_input_level;
        end
        gp_pkg::reg_p6_w0: begin
          s_next.rdata[`GP_LO_LSB +: 8] = p6_view[0];
          s_next.rdata[`GP_HI_LSB +: 8] = p6_view[1];
        end
        gp_pkg::reg_p6_w1: begin
          s_next.rdata[`GP_LO_LSB +: 8] = p6_view[2];
          s_next.rdata[`GP_HI_LSB +: 8] = p6_view[3];
        end
        gp_pkg::reg_p6_w2: begin
          s_next.rdata[`GP_LO_LSB +: 8] = p6_view[4];
          s_next.rdata[`GP_HI_LSB +: 8] = p6_view[5];
        end
        gp_pkg::reg_p6_w3: begin
          s_next.rdata[`GP_LO_LSB +: 8] = p6_view[6];
          s_next.rdata[`GP_HI_LSB +: 8] = p6_view[7];
        end
        gp_pkg::reg_lcd_mode: begin
          s_next.rdata[`GP_LCD_MODE_BIT] = s_reg.lcd_mode;
        end
        default: begin
          s_next.rdata = `GP_ZERO_WORD;
        end
      endcase
    end
    // address phase
    if (accept) begin
      s_next.addr_q = decode_addr(haddr);
      s_next.wr_pend = take_wr;
      s_next.rd_pend = take_rd;
      s_next.readyout = hwrite;
    end
    // segment outputs, slot j is segment j+2
    for (int j = 0; j < 8; j++) begin
      if (s_reg.lcd_mode) begin
        s_next.seg[j] = s_reg.p6_cfg[j] & duty_mask;
      end else begin
        s_next.seg[j] = `GP_ZERO_SEG;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
      s_reg.readyout <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_comb begin
    port2_hold = `GP_ZERO_BYTE;
    port3_hold = `GP_ZERO_BYTE;
    port3_hold[`GP_OPAMP_PIN] = opamp_pin_output_enable;
    port3_hold[`GP_REF_PIN] = reference_out_enable;
  end

  // ----------------------------------------
  // port 6 pin controls
  // ----------------------------------------
  always_comb begin
    for (int k = 0; k < 8; k++) begin
      port6_pin_output_enable[k] = s_reg.p6_cfg[k][`GP_P6_OE_BIT];
      port6_pin_input_enable[k] = s_reg.p6_cfg[k][`GP_P6_IE_BIT];
      port6_pin_output_value[k] = s_reg.p6_cfg[k][`GP_P6_DO_BIT];
    end
  end

  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_pin
      gp_pin_cell u_p2 (
        .hclk(hclk),
        .hresetn(hresetn),
        .pullup_req(s_reg.p2_pu[i]),
        .output_req(s_reg.p2_oe[i]),
        .value_req(s_reg.p2_do[i]),
        .input_req(s_reg.p2_ie[i]),
        .analog_hold(port2_hold[i]),
        .pad_in(port2_pad_in[i]),
        .pad(port2_pad[i]),
        .level(port2_input_level[i])
      );
      gp_pin_cell u_p3 (
        .hclk(hclk),
        .hresetn(hresetn),
        .pullup_req(s_reg.p3_pu[i]),
        .output_req(s_reg.p3_oe[i]),
        .value_req(s_reg.p3_do[i]),
        .input_req(s_reg.p3_ie[i]),
        .analog_hold(port3_hold[i]),
        .pad_in(port3_pad_in[i]),
        .pad(port3_pad[i]),
        .level(port3_input_level[i])
      );
      gp_pin_cell u_p6 (
        .hclk(hclk),
        .hresetn(hresetn),
        .pullup_req(1'b0),
        .output_req(port6_pin_output_enable[i]),
        .value_req(port6_pin_output_value[i]),
        .input_req(port6_pin_input_enable[i]),
        .analog_hold(s_reg.lcd_mode),
        .pad_in(port6_pad_in[i]),
        .pad(port6_pad[i]),
        .level(port6_pin_input_level[i])
      );
    end
  endgenerate

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = s_reg.rdata;
  assign hreadyout = s_reg.readyout;
  assign hresp = s_reg.resp;
  assign lcd_segment_data = s_reg.seg;

endmodule : gp_ports_top
`default_nettype wire

// [rtl/gp_defines.svh]
// Function
// - port 3 word 0 bits 23..16 switch each pin's pull-up
// - port 3 word 0 bits 7..0 switch each pin's output driver
// - port 3 word 1 bits 7..0 give each driven pin's level
// - port 3 word 1 bits 23..16 switch each pin's input buffer
// - port 3 word 2 bits 7..0 read back each pin's level
// - port 3 word 2 bit 17 shows op-amp routing onto pin 1
// - each port 6 pin has output enable, value, input enable, level
// - port 6 fields sit in four words, pin 2k low byte, 2k+1 high
// - mode register chooses segment data or pin configuration in those words
// - segments two to nine map in order onto the port 6 bytes
// - used segment bits follow duty: six, five, four or three bits
// - port 2 has pull-up, output enable and input enable fields
`ifndef GP_DEFINES_SVH
`define GP_DEFINES_SVH

// ----------------------------------------
// register addresses
// ----------------------------------------
`define GP_ADDR_P2_W0 32'h00040810
`define GP_ADDR_P2_W1 32'h00040814
`define GP_ADDR_P2_W2 32'h00040818
`define GP_ADDR_P3_W0 32'h00040820
`define GP_ADDR_P3_W1 32'h00040824
`define GP_ADDR_P3_W2 32'h00040828
`define GP_ADDR_P6_W0 32'h00040850
`define GP_ADDR_P6_W1 32'h00040854
`define GP_ADDR_P6_W2 32'h00040858
`define GP_ADDR_P6_W3 32'h0004085C
`define GP_ADDR_LCD_MODE 32'h00041B04

// ----------------------------------------
// field positions
// ----------------------------------------
`define GP_LO_LSB 0
`define GP_HI_LSB 16
`define GP_ROUTE_BIT 17
`define GP_LCD_MODE_BIT 0
`define GP_P6_OE_BIT 3
`define GP_P6_IE_BIT 2
`define GP_P6_DO_BIT 1
`define GP_P6_DI_BIT 0
`define GP_HTRANS_ACT_BIT 1
`define GP_OPAMP_PIN 7
`define GP_REF_PIN 6

// ----------------------------------------
// values
// ----------------------------------------
`define GP_ZERO_BYTE 8'h00
`define GP_ZERO_WORD 32'h00000000
`define GP_ZERO_SEG 6'h00
`define GP_MASK_D3 6'h07
`define GP_MASK_D4 6'h0F
`define GP_MASK_D5 6'h1F
`define GP_MASK_D6 6'h3F

`endif

// [rtl/gp_pkg.sv]
package gp_pkg;

  typedef struct packed {
    logic pu;
    logic ie;
    logic oe;
    logic out;
  } gp_pad_t;

  typedef enum logic [3:0] {
    reg_none, reg_p2_w0, reg_p2_w1, reg_p2_w2,
    reg_p3_w0, reg_p3_w1, reg_p3_w2,
    reg_p6_w0, reg_p6_w1, reg_p6_w2, reg_p6_w3, reg_lcd_mode
  } gp_reg_t;

  typedef enum logic [1:0] {
    duty_1_3, duty_1_4, duty_1_5, duty_1_6
  } gp_duty_t;

  typedef struct packed {
    gp_pad_t pad;
    logic level;
  } gp_cell_state_t;

  typedef struct packed {
    logic [7:0] p2_pu;
    logic [7:0] p2_oe;
    logic [7:0] p2_ie;
    logic [7:0] p2_do;
    logic [7:0] p3_pu;
    logic [7:0] p3_oe;
    logic [7:0] p3_ie;
    logic [7:0] p3_do;
    logic [7:0][5:0] p6_cfg;
    logic lcd_mode;
    logic [7:0][5:0] seg;
    logic wr_pend;
    logic rd_pend;
    gp_reg_t addr_q;
    logic [31:0] rdata;
    logic readyout;
    logic resp;
  } gp_top_state_t;

endpackage : gp_pkg

// [rtl/gp_pin_cell.sv]
`timescale 1ns/1ps
`default_nettype none
module gp_pin_cell (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pullup_req,
  input wire logic output_req,
  input wire logic value_req,
  input wire logic input_req,
  input wire logic analog_hold,
  input wire logic pad_in,
  output var gp_pkg::gp_pad_t pad,
  output var logic level
);

  gp_pkg::gp_cell_state_t s_reg;
  gp_pkg::gp_cell_state_t s_next;

  // ----------------------------------------
  // pad drive and input buffer
  // ----------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.pad.pu = pullup_req & ~analog_hold;
    s_next.pad.oe = output_req & ~analog_hold;
    s_next.pad.out = value_req;
    s_next.pad.ie = input_req & ~analog_hold;
    // buffer off reads low
    s_next.level = pad_in & input_req & ~analog_hold;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign pad = s_reg.pad;
  assign level = s_reg.level;

endmodule : gp_pin_cell
`default_nettype wire

// [verification/gp_ports_props.sv]
`timescale 1ns/1ps
`default_nettype none
module gp_ports_props (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic opamp_pin_output_enable,
  input wire logic reference_out_enable,
  input wire logic opamp_to_pin1_route_enable,
  input wire gp_pkg::gp_duty_t lcd_duty,
  input wire gp_pkg::gp_pad_t [7:0] port3_pad,
  input wire gp_pkg::gp_pad_t [7:0] port6_pad,
  input wire logic [7:0][5:0] lcd_segment_data
);
  logic take;
  logic rd_st;
  logic p6_pu;
  logic seg_over;
  logic [5:0] mask;
  assign take = hsel & hready & htrans[1];
  assign rd_st = take & !hwrite & (haddr == 32'h00040828);
  always_comb begin
    p6_pu = 1'b0;
    seg_over = 1'b0;
    case (lcd_duty)
      gp_pkg::duty_1_3: mask = 6'h07;
      gp_pkg::duty_1_4: mask = 6'h0F;
      gp_pkg::duty_1_5: mask = 6'h1F;
      default: mask = 6'h3F;
    endcase
    for (int i = 0; i < 8; i++) begin
      p6_pu = p6_pu | port6_pad[i].pu;
      seg_over = seg_over | (|(lcd_segment_data[i] & ~mask));
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("error response seen");
  a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (take && hwrite |=> hreadyout)
    else $error("write stalled");
  a_p6_no_pull: assert property (!p6_pu)
    else $error("port6 pull-up driven");
  a_opamp_frees: assert property (opamp_pin_output_enable [*3] |->
    !port3_pad[7].pu && !port3_pad[7].oe && !port3_pad[7].ie) else $error("pin7 not freed");
  a_ref_frees: assert property (reference_out_enable [*3] |->
    !port3_pad[6].pu && !port3_pad[6].oe && !port3_pad[6].ie) else $error("pin6 not freed");
  a_duty_mask: assert property ($stable(lcd_duty) |-> !seg_over)
    else $error("segment bit above duty");
  a_route_show: assert property ((rd_st && opamp_to_pin1_route_enable) ##1
    opamp_to_pin1_route_enable ##1 opamp_to_pin1_route_enable |-> hrdata[17]) else $error("route bit lost");
  a_w2_reserved: assert property (rd_st |-> ##2 hrdata[31:18] == 14'h0 && hrdata[16:8] == 9'h0)
    else $error("reserved bits set");
endmodule : gp_ports_props
`default_nettype wire

// [verification/gp_pin_model.sv]
`timescale 1ns/1ps
`default_nettype none
module gp_pin_model (
  input wire gp_pkg::gp_pad_t [7:0] pad,
  input wire logic [7:0] ext,
  input wire logic [7:0] ext_en,
  output logic [7:0] level
);
  // ----------------------------------------
  // pin level resolution
  // ----------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad[i].oe) begin
        level[i] = pad[i].out;
      end else if (ext_en[i]) begin
        level[i] = ext[i];
      end else if (pad[i].pu) begin
        level[i] = 1'b1;
      end else begin
        level[i] = ~pad[i].out;
      end
    end
  end
endmodule : gp_pin_model
`default_nettype wire

// [verification/tb_gp_ports_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "gp_defines.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_gp_ports_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic [7:0] p2_in, p3_in, p6_in;
  logic [7:0] p3_en = 8'h40;
  logic [7:0] p6_en = 8'hFF;
  logic opa = 1'b0, reference_voltage_pin = 1'b0, route = 1'b0;
  gp_pkg::gp_duty_t duty = gp_pkg::duty_1_6;
  gp_pkg::gp_pad_t [7:0] p2_pad, p3_pad, p6_pad;
  logic [7:0][5:0] seg;
  logic [5:0] m;
  int error_cnt = 0;
  int n_checks = 0;
  always #2 hclk = ~hclk;
  gp_ports_top u_gp_ports_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .port2_pad_in(p2_in),
    .port3_pad_in(p3_in), .port6_pad_in(p6_in), .opamp_pin_output_enable(opa),
    .reference_out_enable(reference_voltage_pin), .opamp_to_pin1_route_enable(route), .lcd_duty(duty),
    .port2_pad(p2_pad), .port3_pad(p3_pad), .port6_pad(p6_pad), .lcd_segment_data(seg));
  gp_pin_model u_gp_pin_model (.pad(p2_pad), .ext(8'h00), .ext_en(8'h00), .level(p2_in));
  gp_pin_model u_gp_pin_model_3 (.pad(p3_pad), .ext(8'h00), .ext_en(p3_en), .level(p3_in));
  gp_pin_model u_gp_pin_model_6 (.pad(p6_pad), .ext(8'hFF), .ext_en(p6_en), .level(p6_in));
  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      summarize();
    end
  endtask : wait_rdy
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
  endtask : xfer
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask : wr
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask : rd_chk
  task automatic settle();
    repeat (3) @(posedge hclk);
  endtask : settle
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(`GP_ADDR_P3_W0, 32'h0);
    wr(`GP_ADDR_P3_W0, 32'hFFFFFFFF);
    rd_chk(`GP_ADDR_P3_W0, 32'h00FF00FF);
    wr(32'h00040830, 32'hFFFFFFFF);
    rd_chk(32'h00040830, 32'h0);
    wr(`GP_ADDR_P3_W2, 32'hFFFFFFFF);
    $display("test registers done");
    wr(`GP_ADDR_P3_W0, 32'h00F0000F);
    wr(`GP_ADDR_P3_W1, 32'h00F00005);
    rd_chk(`GP_ADDR_P3_W1, 32'h00F00005);
    settle();
    `CHK(p3_pad[0], 4'h3)
    `CHK(p3_pad[1], 4'h2)
    `CHK(p3_pad[4], 4'hC)
    rd_chk(`GP_ADDR_P3_W2, 32'h000000B0);
    route <= 1'b1;
    settle();
    rd_chk(`GP_ADDR_P3_W2, 32'h000200B0);
    wr(`GP_ADDR_P3_W0, 32'h0030000F);
    wr(`GP_ADDR_P3_W1, 32'h00300005);
    opa <= 1'b1;
    reference_voltage_pin <= 1'b1;
    settle();
    `CHK(p3_pad[7], 4'h0)
    `CHK(p3_pad[6], 4'h0)
    rd_chk(`GP_ADDR_P3_W2, 32'h00020030);
    opa <= 1'b0;
    reference_voltage_pin <= 1'b0;
    $display("test port3 done");
    wr(`GP_ADDR_P2_W0, 32'h00010002);
    wr(`GP_ADDR_P2_W1, 32'h00010002);
    settle();
    `CHK(p2_pad[1], 4'h3)
    `CHK(p2_pad[0], 4'hC)
    rd_chk(`GP_ADDR_P2_W2, 32'h00000001);
    $display("test port2 done");
    for (int k = 0; k < 4; k++) wr(`GP_ADDR_P6_W0 + 4 * k, 32'h000A0004);
    settle();
    for (int k = 0; k < 4; k++) rd_chk(`GP_ADDR_P6_W0 + 4 * k, 32'h000A0005);
    `CHK(p6_pad[7], 4'h3)
    `CHK(p6_pad[6], 4'h4)
    $display("test port6 done");
    wr(`GP_ADDR_LCD_MODE, 32'hFFFFFFFF);
    rd_chk(`GP_ADDR_LCD_MODE, 32'h1);
    for (int k = 0; k < 4; k++) wr(`GP_ADDR_P6_W0 + 4 * k, 32'h003C001D + 32'h00010001 * k);
    settle();
    for (int k = 0; k < 4; k++) begin
      rd_chk(`GP_ADDR_P6_W0 + 4 * k, 32'h003C001D + 32'h00010001 * k);
      `CHK(seg[2 * k], 6'h1D + 6'(k))
      `CHK(seg[2 * k + 1], 6'h3C + 6'(k))
    end
    `CHK(p6_pad[7].oe, 1'b0)
    for (int d = 0; d < 4; d++) begin
      duty <= gp_pkg::gp_duty_t'(d);
      m = 6'h3F >> (3 - d);
      settle();
      `CHK(seg[0], 6'h1D & m)
      `CHK(seg[1], 6'h3C & m)
    end
    wr(`GP_ADDR_LCD_MODE, 32'h0);
    settle();
    `CHK(seg[0], 6'h00)
    $display("test lcd done");
    summarize();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    summarize();
  end
endmodule : tb_gp_ports_top
bind gp_ports_top gp_ports_props u_gp_ports_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .opamp_pin_output_enable(opamp_pin_output_enable),
  .reference_out_enable(reference_out_enable), .opamp_to_pin1_route_enable(opamp_to_pin1_route_enable),
  .lcd_duty(lcd_duty), .port3_pad(port3_pad), .port6_pad(port6_pad), .lcd_segment_data(lcd_segment_data));
`default_nettype wire
